// >>> verilog/pdc_top.sv
// Added by the designer: the address map and the Avalon-MM slave port.
`timescale 1ns/10ps
module pdc_top #(
  parameter logic [pdc_pkg::CNT_W-1:0] IDLE_TIMEOUT_CYC = pdc_pkg::IDLE_TIMEOUT_CYC
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic [pdc_pkg::NUM_CH-1:0] i_pwm_in,
  input wire logic i_idle_behaviour_select,
  input wire logic i_reference_source_select,
  input wire logic i_power_down_n,
  input wire logic [pdc_pkg::ADDR_W-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  output logic [pdc_pkg::CODE_BITS-1:0] o_channel_voltage_a,
  output logic [pdc_pkg::CODE_BITS-1:0] o_channel_voltage_b,
  output logic [pdc_pkg::NUM_CH-1:0] o_channel_drive_en,
  output logic o_internal_ref_en,
  output logic o_external_ref_sel
);

  localparam int NS = pdc_pkg::NUM_CH + 3;
  localparam int CW = pdc_pkg::CNT_W;
  localparam int NB = pdc_pkg::CODE_BITS;

  logic [NS-1:0] sync1_ff;
  logic [NS-1:0] sync2_ff;
  logic [1:0] init_cnt_ff;
  logic init_done;
  logic idle_sel;
  logic ref_sel;
  logic pd_act;
  logic soft_pd_ff;
  logic wait_ff;
  logic [31:0] rdata_ff;
  logic int_ref_ff;
  logic ext_ref_ff;
  logic [pdc_pkg::NUM_CH-1:0] awake_vec;
  logic [pdc_pkg::NUM_CH-1:0][NB-1:0] code_vec;

  // pins are asynchronous; only the second stage is ever looked at
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
    end else begin
      sync1_ff <= {i_power_down_n, i_reference_source_select, i_idle_behaviour_select,
                   i_pwm_in};
      sync2_ff <= sync1_ff;
    end
  end

  assign idle_sel = sync2_ff[pdc_pkg::NUM_CH];
  assign ref_sel = sync2_ff[pdc_pkg::NUM_CH + 1];
  assign pd_act = ~sync2_ff[pdc_pkg::NUM_CH + 2] | soft_pd_ff;

  // straps are only trusted once the synchroniser has filled
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      init_cnt_ff <= 2'h0;
    end else if (init_cnt_ff != pdc_pkg::INIT_DONE_CNT) begin
      init_cnt_ff <= init_cnt_ff + 2'h1;
    end
  end

  assign init_done = (init_cnt_ff == pdc_pkg::INIT_DONE_CNT);

  for (genvar c = 0; c < pdc_pkg::NUM_CH; c++) begin : g_ch
    logic lvl;
    logic prev_ff;
    logic rise;
    logic edge_any;
    logic timeout;
    logic pair_ok;
    logic start;
    logic [CW-1:0] per_cnt_ff;
    logic [CW-1:0] hi_cnt_ff;
    logic [CW-1:0] stb_cnt_ff;
    logic [CW-1:0] per_ff;
    logic [CW:0] rem_ff;
    logic [CW:0] rem_sh;
    logic [NB-1:0] quo_ff;
    logic [NB-1:0] code_ff;
    logic [pdc_pkg::DLY_W-1:0] dly_ff;
    logic busy_ff;
    logic drv_ff;
    logic awake_ff;
    logic have_prev_ff;
    logic force_zero_ff;
    logic force_full_ff;

    assign lvl = sync2_ff[c];
    assign rise = lvl & ~prev_ff;
    assign edge_any = lvl ^ prev_ff;
    assign timeout = ~edge_any && (stb_cnt_ff == IDLE_TIMEOUT_CYC - CW'(1));
    // a pair farther apart than the timeout saturates the period count
    assign pair_ok = have_prev_ff && (per_cnt_ff < IDLE_TIMEOUT_CYC)
                     && (per_cnt_ff >= CW'(pdc_pkg::COMPUTE_DELAY_CYC));
    assign start = rise && pair_ok && init_done && !pd_act;
    assign rem_sh = {rem_ff[CW-1:0], 1'b0};

    always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
        prev_ff <= 1'b0;
        per_cnt_ff <= '0;
        hi_cnt_ff <= '0;
        stb_cnt_ff <= '0;
      end else begin
        prev_ff <= lvl;
        if (rise) begin
          per_cnt_ff <= CW'(1);
          hi_cnt_ff <= CW'(1);
        end else begin
          if (per_cnt_ff != IDLE_TIMEOUT_CYC) begin
            per_cnt_ff <= per_cnt_ff + CW'(1);
          end
          if (lvl && hi_cnt_ff != IDLE_TIMEOUT_CYC) begin
            hi_cnt_ff <= hi_cnt_ff + CW'(1);
          end
        end
        // restarting on either edge lets an idle-high channel later time out low
        if (edge_any) begin
          stb_cnt_ff <= '0;
        end else if (stb_cnt_ff != IDLE_TIMEOUT_CYC) begin
          stb_cnt_ff <= stb_cnt_ff + CW'(1);
        end
      end
    end

    // restoring division, one quotient bit per cycle, done well inside the delay
    always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
        rem_ff <= '0;
        per_ff <= '0;
        quo_ff <= '0;
        force_zero_ff <= 1'b0;
        force_full_ff <= 1'b0;
      end else if (start) begin
        rem_ff <= {1'b0, hi_cnt_ff};
        per_ff <= per_cnt_ff;
        quo_ff <= '0;
        force_zero_ff <= (hi_cnt_ff < pdc_pkg::MIN_HIGH_WIDTH_CYC);
        force_full_ff <= ((per_cnt_ff - hi_cnt_ff) < pdc_pkg::MIN_LOW_WIDTH_CYC);
      end else if (busy_ff && dly_ff < pdc_pkg::DLY_W'(NB)) begin
        // fewer clock ticks per period leave low quotient bits noisy
        if (rem_sh >= {1'b0, per_ff}) begin
          rem_ff <= rem_sh - {1'b0, per_ff};
          quo_ff <= {quo_ff[NB-2:0], 1'b1};
        end else begin
          rem_ff <= rem_sh;
          quo_ff <= {quo_ff[NB-2:0], 1'b0};
        end
      end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
        code_ff <= pdc_pkg::CODE_ZERO;
        drv_ff <= 1'b0;
        awake_ff <= 1'b0;
        have_prev_ff <= 1'b0;
        busy_ff <= 1'b0;
        dly_ff <= '0;
      end else if (!init_done) begin
        busy_ff <= 1'b0;
      end else if (pd_act) begin
        drv_ff <= 1'b0;
        awake_ff <= 1'b0;
        have_prev_ff <= 1'b0;
        busy_ff <= 1'b0;
      end else begin
        if (!idle_sel && !awake_ff) begin
          awake_ff <= 1'b1;
          drv_ff <= 1'b1;
        end
        if (start) begin
          busy_ff <= 1'b1;
          dly_ff <= '0;
        end else if (busy_ff) begin
          dly_ff <= dly_ff + pdc_pkg::DLY_W'(1);
        end
        if (rise) begin
          awake_ff <= 1'b1;
          have_prev_ff <= 1'b1;
        end else if (timeout) begin
          busy_ff <= 1'b0;
          if (!idle_sel) begin
            code_ff <= lvl ? pdc_pkg::CODE_FULL : pdc_pkg::CODE_ZERO;
            drv_ff <= 1'b1;
          end else if (!lvl) begin
            awake_ff <= 1'b0;
            drv_ff <= 1'b0;
            have_prev_ff <= 1'b0;
          end
          // idle high in sample/hold keeps code and drive as they are
        end else if (busy_ff && dly_ff == pdc_pkg::COMPUTE_DELAY_CYC - pdc_pkg::DLY_W'(1)) begin
          busy_ff <= 1'b0;
          drv_ff <= 1'b1;
          if (force_zero_ff) begin
            code_ff <= pdc_pkg::CODE_ZERO;
          end else if (force_full_ff) begin
            code_ff <= pdc_pkg::CODE_FULL;
          end else begin
            code_ff <= quo_ff;
          end
        end
      end
    end

    assign awake_vec[c] = awake_ff;
    assign code_vec[c] = code_ff;
    assign o_channel_drive_en[c] = drv_ff;
  end

  assign o_channel_voltage_a = code_vec[0];
  assign o_channel_voltage_b = code_vec[1];

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      int_ref_ff <= 1'b0;
      ext_ref_ff <= 1'b0;
    end else begin
      ext_ref_ff <= ref_sel;
      int_ref_ff <= init_done && !ref_sel && !pd_act && (|awake_vec);
    end
  end

  assign o_internal_ref_en = int_ref_ff;
  assign o_external_ref_sel = ext_ref_ff;

  function automatic logic [31:0] reg_read(input logic [pdc_pkg::ADDR_W-1:0] addr);
    logic [31:0] v;
    v = 32'h0000_0000;
    case (addr)
      pdc_pkg::REG_CTRL: begin
        v[pdc_pkg::CTRL_SOFT_PD_BIT] = soft_pd_ff;
      end
      pdc_pkg::REG_STATUS: begin
        v[pdc_pkg::STS_DRIVE_LSB +: pdc_pkg::NUM_CH] = o_channel_drive_en;
        v[pdc_pkg::STS_AWAKE_LSB +: pdc_pkg::NUM_CH] = awake_vec;
        v[pdc_pkg::STS_INT_REF_BIT] = int_ref_ff;
        v[pdc_pkg::STS_IDLE_SEL_BIT] = idle_sel;
        v[pdc_pkg::STS_REF_SEL_BIT] = ref_sel;
        v[pdc_pkg::STS_PD_BIT] = pd_act;
      end
      pdc_pkg::REG_CODE_A: begin
        v[NB-1:0] = code_vec[0];
      end
      pdc_pkg::REG_CODE_B: begin
        v[NB-1:0] = code_vec[1];
      end
      default: begin
        v = 32'h0000_0000;
      end
    endcase
    return v;
  endfunction

  // one wait cycle per access: accept, then release at the following edge
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      wait_ff <= 1'b1;
      rdata_ff <= 32'h0000_0000;
    end else if (wait_ff && (i_avs_read || i_avs_write)) begin
      wait_ff <= 1'b0;
      if (i_avs_read) begin
        rdata_ff <= reg_read(i_avs_address);
      end
    end else begin
      wait_ff <= 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      soft_pd_ff <= pdc_pkg::CTRL_SOFT_PD_RESET;
    end else if (!wait_ff && i_avs_write && i_avs_address == pdc_pkg::REG_CTRL
                 && i_avs_byteenable[0]) begin
      soft_pd_ff <= i_avs_writedata[pdc_pkg::CTRL_SOFT_PD_BIT];
    end
  end

  assign o_avs_readdata = rdata_ff;
  assign o_avs_waitrequest = wait_ff;

endmodule

// >>> verilog/pdc_pkg.sv
package pdc_pkg;

  localparam int CLK_HZ = 25_000_000;
  localparam int CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;

  // code width; the same logic builds for 10 or 8 bits
  localparam int CODE_BITS = 12;
  localparam logic [CODE_BITS-1:0] CODE_ZERO = 12'h000;
  localparam logic [CODE_BITS-1:0] CODE_FULL = 12'hfff;
  localparam int NUM_CH = 2;

  // period and idle counters must hold the nominal idle timeout
  localparam int CNT_W = 22;
  localparam int IDLE_TIMEOUT_MIN_MS = 50;
  localparam int IDLE_TIMEOUT_MS = 60;
  localparam int IDLE_TIMEOUT_MAX_MS = 70;
  localparam int IDLE_TIMEOUT_CYC_INT = IDLE_TIMEOUT_MS * (CLK_HZ / 1000);
  localparam logic [CNT_W-1:0] IDLE_TIMEOUT_CYC = CNT_W'(IDLE_TIMEOUT_CYC_INT);

  localparam int DLY_W = 8;
  localparam int COMPUTE_DELAY_NS = 3200;
  localparam int COMPUTE_DELAY_CYC_INT = COMPUTE_DELAY_NS / CLK_PERIOD_NS;
  localparam logic [DLY_W-1:0] COMPUTE_DELAY_CYC = DLY_W'(COMPUTE_DELAY_CYC_INT);

  localparam int MIN_HIGH_WIDTH_NS = 25;
  localparam int MIN_LOW_WIDTH_NS = 25;
  localparam logic [CNT_W-1:0] MIN_HIGH_WIDTH_CYC =
    CNT_W'((MIN_HIGH_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] MIN_LOW_WIDTH_CYC =
    CNT_W'((MIN_LOW_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  localparam logic [1:0] INIT_DONE_CNT = 2'h3;

  // register map, byte addresses
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] REG_STATUS = 4'h4;
  localparam logic [ADDR_W-1:0] REG_CODE_A = 4'h8;
  localparam logic [ADDR_W-1:0] REG_CODE_B = 4'hc;
  localparam int CTRL_SOFT_PD_BIT = 0;
  localparam logic CTRL_SOFT_PD_RESET = 1'b0;
  localparam int STS_DRIVE_LSB = 0;
  localparam int STS_AWAKE_LSB = 2;
  localparam int STS_INT_REF_BIT = 4;
  localparam int STS_IDLE_SEL_BIT = 5;
  localparam int STS_REF_SEL_BIT = 6;
  localparam int STS_PD_BIT = 7;

endpackage

// >>> verification/pdc_pwm_model.sv
`timescale 1ns/10ps
module pdc_pwm_model (
  input wire logic i_clk,
  input wire logic i_run,
  input wire logic i_idle_level,
  input wire logic [15:0] i_period,
  input wire logic [15:0] i_high,
  output logic o_pwm
);
  logic [15:0] cnt = 16'h0;
  logic [15:0] per = 16'h0;
  logic [15:0] hi = 16'h0;
  initial o_pwm = 1'b0;
  // new shape only at a period boundary, so no odd period is made
  always @(posedge i_clk) begin
    if (!i_run) begin
      o_pwm <= i_idle_level;
      cnt <= 16'h0;
    end else begin
      if (cnt == 16'h0) begin
        per = i_period;
        hi = i_high;
      end
      o_pwm <= (cnt < hi);
      cnt <= (cnt + 16'h1 >= per) ? 16'h0 : cnt + 16'h1;
    end
  end
endmodule

// >>> verification/pdc_top_props.sv
`timescale 1ns/10ps
module pdc_top_props #(
  parameter logic [pdc_pkg::CNT_W-1:0] IDLE_TIMEOUT_CYC = pdc_pkg::IDLE_TIMEOUT_CYC
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic [pdc_pkg::NUM_CH-1:0] i_pwm_in,
  input wire logic i_idle_behaviour_select,
  input wire logic i_reference_source_select,
  input wire logic i_power_down_n,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic o_avs_waitrequest,
  input wire logic [pdc_pkg::CODE_BITS-1:0] o_channel_voltage_a,
  input wire logic [pdc_pkg::CODE_BITS-1:0] o_channel_voltage_b,
  input wire logic [pdc_pkg::NUM_CH-1:0] o_channel_drive_en,
  input wire logic o_internal_ref_en,
  input wire logic o_external_ref_sel
);
  logic [1:0] pin_q_ff;
  logic [pdc_pkg::CNT_W-1:0] rise_a_ff;
  logic [pdc_pkg::CNT_W-1:0] rise_b_ff;
  logic [pdc_pkg::CNT_W-1:0] stab_a_ff;
  // saturating, so a long idle never wraps back into the update window
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pin_q_ff <= 2'h0;
      rise_a_ff <= '1;
      rise_b_ff <= '1;
      stab_a_ff <= '0;
    end else begin
      pin_q_ff <= i_pwm_in;
      if (i_pwm_in[0] && !pin_q_ff[0]) rise_a_ff <= '0;
      else if (rise_a_ff != '1) rise_a_ff <= rise_a_ff + 22'h1;
      if (i_pwm_in[1] && !pin_q_ff[1]) rise_b_ff <= '0;
      else if (rise_b_ff != '1) rise_b_ff <= rise_b_ff + 22'h1;
      if (i_pwm_in[0] != pin_q_ff[0] || !i_power_down_n) stab_a_ff <= '0;
      else if (stab_a_ff != '1) stab_a_ff <= stab_a_ff + 22'h1;
    end
  end
  a_upd_delay_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    i_idle_behaviour_select && $changed(o_channel_voltage_a) |-> rise_a_ff inside {[60:110]})
    else $error("code a changed outside its update slot");
  a_own_edge_b: assert property (@(posedge i_clk) disable iff (!i_rstn)
    i_idle_behaviour_select && $changed(o_channel_voltage_b) |-> rise_b_ff inside {[60:110]})
    else $error("code b changed without its own edge");
  a_trans_full: assert property (@(posedge i_clk) disable iff (!i_rstn)
    !i_idle_behaviour_select && i_pwm_in[0] && stab_a_ff == IDLE_TIMEOUT_CYC + 22'hc |->
    o_channel_voltage_a == pdc_pkg::CODE_FULL && o_channel_drive_en[0])
    else $error("idle high did not give full scale");
  a_trans_zero: assert property (@(posedge i_clk) disable iff (!i_rstn)
    !i_idle_behaviour_select && !i_pwm_in[0] && stab_a_ff == IDLE_TIMEOUT_CYC + 22'hc |->
    o_channel_voltage_a == pdc_pkg::CODE_ZERO)
    else $error("idle low did not give zero scale");
  a_hold_lo_hiz: assert property (@(posedge i_clk) disable iff (!i_rstn)
    i_idle_behaviour_select && !i_pwm_in[0] && stab_a_ff == IDLE_TIMEOUT_CYC + 22'hc |->
    !o_channel_drive_en[0])
    else $error("idle low in hold mode still drives");
  a_pd_all_off: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (!i_power_down_n)[*4] |-> o_channel_drive_en == 2'h0 && !o_internal_ref_en)
    else $error("power-down pin left something on");
  a_ext_ref_off: assert property (@(posedge i_clk) disable iff (!i_rstn)
    i_reference_source_select[*6] |-> o_external_ref_sel && !o_internal_ref_en)
    else $error("external reference not taken over");
  a_reset_state: assert property (@(posedge i_clk) disable iff (!i_rstn)
    $rose(i_rstn) |-> ##[4:6] (o_channel_drive_en == {2{!i_idle_behaviour_select}} &&
    o_channel_voltage_a == pdc_pkg::CODE_ZERO))
    else $error("wrong state after reset");
  a_bus_answer: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest ##1 o_avs_waitrequest)
    else $error("bus answer not one cycle after request");
endmodule
bind pdc_top pdc_top_props #(.IDLE_TIMEOUT_CYC(IDLE_TIMEOUT_CYC)) u_props (.i_clk(i_clk),
  .i_rstn(i_rstn), .i_pwm_in(i_pwm_in), .i_idle_behaviour_select(i_idle_behaviour_select),
  .i_reference_source_select(i_reference_source_select), .i_power_down_n(i_power_down_n),
  .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .o_avs_waitrequest(o_avs_waitrequest),
  .o_channel_voltage_a(o_channel_voltage_a), .o_channel_voltage_b(o_channel_voltage_b),
  .o_channel_drive_en(o_channel_drive_en), .o_internal_ref_en(o_internal_ref_en),
  .o_external_ref_sel(o_external_ref_sel));

// >>> verification/testbench.sv
`timescale 1ns/10ps
module testbench;
  logic i_clk = 1'b0, i_rstn = 1'b0, i_idle_behaviour_select = 1'b0;
  logic i_reference_source_select = 1'b0, i_power_down_n = 1'b1;
  logic i_avs_read = 1'b0, i_avs_write = 1'b0, o_avs_waitrequest;
  logic o_internal_ref_en, o_external_ref_sel;
  logic [3:0] i_avs_address = 4'h0;
  logic [31:0] i_avs_writedata = 32'h0, o_avs_readdata, rd;
  logic [1:0] i_pwm_in, run = 2'h0, lvl = 2'h0, o_channel_drive_en;
  logic [15:0] per_a = 16'hc8, hi_a = 16'h32;
  logic [pdc_pkg::CODE_BITS-1:0] o_channel_voltage_a, o_channel_voltage_b;
  int bad_count = 0, n_checks = 0, cyc = 0;
  always #20 i_clk = ~i_clk;
  // short timeout keeps idle scenarios to a few thousand cycles
  pdc_top #(.IDLE_TIMEOUT_CYC(22'h7d0)) dut (.i_clk(i_clk), .i_rstn(i_rstn),
    .i_pwm_in(i_pwm_in), .i_idle_behaviour_select(i_idle_behaviour_select),
    .i_reference_source_select(i_reference_source_select), .i_power_down_n(i_power_down_n),
    .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
    .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(4'h1),
    .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
    .o_channel_voltage_a(o_channel_voltage_a), .o_channel_voltage_b(o_channel_voltage_b),
    .o_channel_drive_en(o_channel_drive_en), .o_internal_ref_en(o_internal_ref_en),
    .o_external_ref_sel(o_external_ref_sel));
  pdc_pwm_model u_src_a (.i_clk(i_clk), .i_run(run[0]), .i_idle_level(lvl[0]),
    .i_period(per_a), .i_high(hi_a), .o_pwm(i_pwm_in[0]));
  pdc_pwm_model u_src_b (.i_clk(i_clk), .i_run(run[1]), .i_idle_level(lvl[1]),
    .i_period(16'h190), .i_high(16'h12c), .o_pwm(i_pwm_in[1]));
  task end_of_test;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 40000) begin
      bad_count++;
      end_of_test();
    end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task wt(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  // one edge before raising, so a release and a new request never share a step
  task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_clk);
    i_avs_read <= !wr;
    i_avs_write <= wr;
    i_avs_address <= a;
    i_avs_writedata <= d;
    do begin
      @(posedge i_clk);
      n++;
    end while (o_avs_waitrequest !== 1'b0 && n < 40);
    rd = o_avs_readdata;
    i_avs_read <= 1'b0;
    i_avs_write <= 1'b0;
    if (n >= 40) chk(32'h1, 32'h0, "bus hang");
  endtask
  task do_reset(input logic sel);
    i_rstn <= 1'b0;
    i_idle_behaviour_select <= sel;
    wt(3);
    i_rstn <= 1'b1;
    wt(8);
    chk(o_channel_drive_en, {2{!sel}}, "reset drive");
    chk(o_channel_voltage_a, 12'h000, "reset code");
    $display("test reset done");
  endtask
  task t_duty;
    run <= 2'h3;
    wt(2000);
    chk(o_channel_voltage_a, 12'h400, "code a");
    chk(o_channel_voltage_b, 12'hc00, "code b");
    bus(1'b0, pdc_pkg::REG_CODE_A, 32'h0);
    chk(rd, 32'h400, "code a reg");
    bus(1'b0, 4'h2, 32'h0);
    chk(rd, 32'h0, "unmapped read");
    $display("test duty done");
  endtask
  task t_short;
    per_a <= 16'h3c;
    hi_a <= 16'h1e;
    wt(600);
    chk(o_channel_voltage_a, 12'h400, "short period kept");
    $display("test short done");
  endtask
  task t_idle_tr;
    run[0] <= 1'b0;
    lvl[0] <= 1'b1;
    wt(2100);
    chk(o_channel_voltage_a, 12'hfff, "idle high");
    lvl[0] <= 1'b0;
    wt(2100);
    chk(o_channel_voltage_a, 12'h000, "idle high then low");
    chk(o_channel_voltage_b, 12'hc00, "b untouched");
    $display("test idle done");
  endtask
  task t_pdown;
    i_power_down_n <= 1'b0;
    wt(8);
    chk({o_channel_drive_en, o_internal_ref_en}, 3'h0, "pin power-down");
    i_power_down_n <= 1'b1;
    wt(10);
    chk(o_channel_drive_en, 2'h3, "resume");
    bus(1'b1, pdc_pkg::REG_CTRL, 32'h1);
    wt(6);
    chk(o_channel_drive_en, 2'h0, "soft power-down");
    bus(1'b0, pdc_pkg::REG_CTRL, 32'h0);
    chk(rd, 32'h1, "ctrl readback");
    bus(1'b1, pdc_pkg::REG_CTRL, 32'h0);
    wt(6);
    chk(o_channel_drive_en, 2'h3, "soft resume");
    $display("test power-down done");
  endtask
  task t_ref;
    i_reference_source_select <= 1'b1;
    wt(8);
    chk({o_external_ref_sel, o_internal_ref_en}, 2'h2, "external ref");
    i_reference_source_select <= 1'b0;
    wt(8);
    chk({o_external_ref_sel, o_internal_ref_en}, 2'h1, "internal ref");
    $display("test reference done");
  endtask
  task t_sh;
    run <= 2'h0;
    do_reset(1'b1);
    i_power_down_n <= 1'b0;
    wt(10);
    i_power_down_n <= 1'b1;
    wt(10);
    chk(o_internal_ref_en, 1'b0, "asleep until edge");
    per_a <= 16'hc8;
    hi_a <= 16'h64;
    run <= 2'h3;
    wt(150);
    chk(o_channel_drive_en, 2'h0, "hi-z after one edge");
    chk(o_internal_ref_en, 1'b1, "awake on edge");
    wt(850);
    chk(o_channel_drive_en, 2'h3, "drive after pair");
    chk(o_channel_voltage_a, 12'h800, "sampled code");
    chk(o_channel_voltage_b, 12'hc00, "sampled code b");
    per_a <= 16'hbb8;
    hi_a <= 16'h9c4;
    wt(7000);
    chk(o_channel_voltage_a, 12'h800, "held code");
    chk(o_channel_drive_en, 2'h3, "held drive");
    run <= 2'h0;
    wt(2100);
    chk(o_channel_drive_en, 2'h0, "idle low hi-z");
    $display("test sample-hold done");
  endtask
  initial begin
    do_reset(1'b0);
    t_duty;
    t_short;
    t_idle_tr;
    t_pdown;
    t_ref;
    t_sh;
    end_of_test;
  end
endmodule
